// File: src/pch_config_regs.sv
// configuration header command, class code and latency registers
`timescale 1ns/1ps
module pch_config_regs #(
  parameter logic [7:0] REVISION_CODE = 8'h5A // arbitrary value
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // configuration access
  input  wire logic        cfg_req,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  output logic             cfg_retry,
  // strap pin
  input  wire logic        class_select_strap,
  // external memory reader
  output logic             mem_rd_req,
  output logic             mem_sel_flash,
  output logic      [18:0] mem_addr,
  input  wire logic        mem_rd_valid,
  input  wire logic [15:0] mem_rd_data,
  input  wire logic        eeprom_present,
  input  wire logic        flash_present,
  // bus events and gating
  input  wire logic        addr_parity_err,
  input  wire logic        data_parity_err,
  output logic             system_error_drive,
  output logic             parity_report,
  input  wire logic        master_req,
  input  wire logic        master_read,
  input  wire logic [7:0]  fifo_free_words,
  output logic             master_grant_ok,
  output logic             use_read_multiple,
  input  wire logic        mem_hit,
  input  wire logic        io_hit,
  output logic             claim_mem,
  output logic             claim_io,
  output logic      [1:0]  devsel_timing,
  output logic      [7:0]  latency_limit
);

  // ==========================================================
  // strap synchroniser
  logic strap_meta_reg;
  logic strap_sync_reg;
  always_ff @(posedge sys_clk) begin
    strap_meta_reg <= class_select_strap;
    strap_sync_reg <= strap_meta_reg;
  end

  // ==========================================================
  // registers
  logic [8:0]  command_reg;
  logic [7:0]  latency_reg;
  logic [7:0]  cache_reg;
  logic [23:0] class_reg;
  logic        class_valid_reg;
  logic        cfg_wren_reg;
  logic        load_done_reg;
  logic        use_flash_reg;
  logic        sig_word_reg;
  pch_pkg::pch_load_e load_state_reg;
  logic [1:0]  class_step_reg;
  logic [31:0] cfg_rdata_reg;
  logic        cfg_ack_reg;

  // ==========================================================
  // decode
  wire logic hit_cmd   = cfg_addr == pch_pkg::OFF_COMMAND_STATUS;
  wire logic hit_class = cfg_addr == pch_pkg::OFF_CLASS_REV;
  wire logic hit_lat   = cfg_addr == pch_pkg::OFF_SELFTEST_LAT;
  wire logic hit_dcfg  = cfg_addr == pch_pkg::OFF_DEVICE_CFG;
  wire logic class_busy = hit_class && !load_done_reg;
  wire logic do_access = cfg_req && !class_busy;
  wire logic do_write  = do_access && cfg_write;
  wire logic class_wr  = do_write && hit_class &&
                         cfg_wren_reg;

  // status bits 19:10 zero, 21 zero, 20 one, 26:25 medium
  wire logic [31:0] cmd_status_word = {5'h00,
    pch_pkg::DEVSEL_MEDIUM,
    3'h0,
    1'h0,
    pch_pkg::CAP_LIST,
    10'h000,
    1'h0,
    command_reg[pch_pkg::BIT_SYSERR_EN],
    1'h0,
    command_reg[pch_pkg::BIT_PARITY_EN],
    3'h0,
    command_reg[2:0]};
  wire logic [23:0] class_default = strap_sync_reg ?
    pch_pkg::CLASS_ATA : pch_pkg::CLASS_RAID;
  wire logic [23:0] class_now = class_valid_reg ? class_reg
                                                : class_default;
  wire logic [31:0] class_word = {class_now, REVISION_CODE};
  wire logic [31:0] lat_word = {16'h0000,
    latency_reg, cache_reg};
  wire logic [31:0] dcfg_word = {31'h0, cfg_wren_reg};
  wire logic [31:0] rd_mux = hit_cmd   ? cmd_status_word :
                             hit_class ? class_word :
                             hit_lat   ? lat_word :
                             hit_dcfg  ? dcfg_word : 32'h00000000;

  // ==========================================================
  // command, latency, cache line and write-enable registers
  logic [8:0] command_next;
  logic [7:0] latency_next;
  logic [7:0] cache_next;
  logic       cfg_wren_next;
  wire logic wr_cmd_lo = do_write && hit_cmd && cfg_byte_en[0];
  wire logic wr_cmd_hi = do_write && hit_cmd && cfg_byte_en[1];
  wire logic wr_cache  = do_write && hit_lat && cfg_byte_en[0];
  wire logic wr_lat    = do_write && hit_lat && cfg_byte_en[1];
  wire logic wr_dcfg   = do_write && hit_dcfg && cfg_byte_en[0];

  // only the writable command bits take write data
  always_comb begin
    command_next  = command_reg;
    latency_next  = latency_reg;
    cache_next    = cache_reg;
    cfg_wren_next = cfg_wren_reg;
    if (wr_cmd_lo) begin
      command_next[2:0] = cfg_wdata[2:0];
      command_next[pch_pkg::BIT_PARITY_EN] = cfg_wdata[6];
    end
    if (wr_cmd_hi) begin
      command_next[pch_pkg::BIT_SYSERR_EN] = cfg_wdata[8];
    end
    if (wr_cache) begin
      cache_next = cfg_wdata[7:0] & pch_pkg::CACHE_MASK;
    end
    if (wr_lat) begin
      latency_next = cfg_wdata[15:8] & pch_pkg::LAT_MASK;
    end
    if (wr_dcfg) begin
      cfg_wren_next = cfg_wdata[pch_pkg::BIT_CLASS_WREN];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      command_reg  <= pch_pkg::COMMAND_RESET;
      latency_reg  <= pch_pkg::LATENCY_RESET;
      cache_reg    <= pch_pkg::CACHE_RESET;
      cfg_wren_reg <= 1'h0;
    end else begin
      command_reg  <= command_next;
      latency_reg  <= latency_next;
      cache_reg    <= cache_next;
      cfg_wren_reg <= cfg_wren_next;
    end
  end

  // ==========================================================
  // external memory class code loader
  wire logic [18:0] sig_addr = use_flash_reg ?
    (sig_word_reg ? pch_pkg::FLASH_ADDR_LO : pch_pkg::FLASH_ADDR_HI) :
    {11'h000, sig_word_reg ? pch_pkg::EEPROM_ADDR_LO
                           : pch_pkg::EEPROM_ADDR_HI};
  wire logic sig_ok = use_flash_reg ?
    (sig_word_reg ? mem_rd_data[7:0] == pch_pkg::FLASH_SIG_LO
                  : mem_rd_data == pch_pkg::FLASH_SIG_HI)
    : mem_rd_data == pch_pkg::EEPROM_SIG;
  wire logic [18:0] class_addr = use_flash_reg ?
    {17'h00000, class_step_reg} + 19'h00010 :
    {17'h00000, class_step_reg} + 19'h00004;
  wire logic any_mem = eeprom_present || flash_present;

  // next values of the loader and the class code
  pch_pkg::pch_load_e load_state_next;
  logic               load_done_next;
  logic               use_flash_next;
  logic               sig_word_next;
  logic [1:0]         class_step_next;
  logic               class_valid_next;
  logic [23:0]        class_next;

  always_comb begin
    load_state_next  = load_state_reg;
    load_done_next   = load_done_reg;
    use_flash_next   = use_flash_reg;
    sig_word_next    = sig_word_reg;
    class_step_next  = class_step_reg;
    class_valid_next = class_valid_reg;
    class_next       = class_reg;
    // untouched lanes keep the default or loaded class code once software takes over
    if (class_wr) begin
      if (!class_valid_reg) begin
        class_next = class_default;
      end
      class_valid_next = 1'h1;
      if (cfg_byte_en[1]) begin
        class_next[7:0] = cfg_wdata[15:8];
      end
      if (cfg_byte_en[2]) begin
        class_next[15:8] = cfg_wdata[23:16];
      end
      if (cfg_byte_en[3]) begin
        class_next[23:16] = cfg_wdata[31:24];
      end
    end
    case (load_state_reg)
      pch_pkg::LD_IDLE: begin
        // flash wins when both memories are fitted
        use_flash_next  = flash_present;
        sig_word_next   = 1'h0;
        load_state_next = any_mem ? pch_pkg::LD_QUERY
                                  : pch_pkg::LD_DONE;
      end
      pch_pkg::LD_QUERY: begin
        load_state_next = pch_pkg::LD_WAIT;
      end
      pch_pkg::LD_WAIT: begin
        // a bad signature leaves the default class code
        if (mem_rd_valid && !sig_ok) begin
          load_state_next = pch_pkg::LD_DONE;
        end else if (mem_rd_valid && sig_word_reg) begin
          class_step_next = 2'h0;
          load_state_next = pch_pkg::LD_CLASS;
        end else if (mem_rd_valid) begin
          sig_word_next   = 1'h1;
          load_state_next = pch_pkg::LD_QUERY;
        end
      end
      pch_pkg::LD_CLASS: begin
        // low class byte first
        if (mem_rd_valid) begin
          case (class_step_reg)
            2'h0: class_next[7:0] = mem_rd_data[7:0];
            2'h1: class_next[15:8] = mem_rd_data[7:0];
            default: class_next[23:16] = mem_rd_data[7:0];
          endcase
          if (class_step_reg == 2'h2) begin
            class_valid_next = 1'h1;
            load_state_next  = pch_pkg::LD_DONE;
          end
          class_step_next = class_step_reg + 2'h1;
        end
      end
      pch_pkg::LD_DONE: begin
        load_done_next = 1'h1;
      end
      default: begin
        load_state_next = pch_pkg::LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      load_state_reg  <= pch_pkg::LD_IDLE;
      load_done_reg   <= 1'h0;
      use_flash_reg   <= 1'h0;
      sig_word_reg    <= 1'h0;
      class_step_reg  <= 2'h0;
      class_valid_reg <= 1'h0;
      class_reg       <= 24'h000000;
    end else begin
      load_state_reg  <= load_state_next;
      load_done_reg   <= load_done_next;
      use_flash_reg   <= use_flash_next;
      sig_word_reg    <= sig_word_next;
      class_step_reg  <= class_step_next;
      class_valid_reg <= class_valid_next;
      class_reg       <= class_next;
    end
  end

  assign mem_rd_req    = load_state_reg == pch_pkg::LD_QUERY ||
                         (load_state_reg == pch_pkg::LD_CLASS &&
                          !mem_rd_valid);
  assign mem_sel_flash = use_flash_reg;
  assign mem_addr      = load_state_reg == pch_pkg::LD_CLASS ?
                         class_addr : sig_addr;

  // ==========================================================
  // configuration answer
  logic [31:0] cfg_rdata_next;
  always_comb begin
    cfg_rdata_next = cfg_rdata_reg;
    if (do_access && !cfg_write) begin
      cfg_rdata_next = rd_mux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_rdata_reg <= 32'h00000000;
      cfg_ack_reg   <= 1'h0;
    end else begin
      cfg_ack_reg   <= do_access;
      cfg_rdata_reg <= cfg_rdata_next;
    end
  end
  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_ack   = cfg_ack_reg;
  assign cfg_retry = cfg_req && class_busy;

  // ==========================================================
  // bus behaviour gating
  wire logic par_en = command_reg[pch_pkg::BIT_PARITY_EN];
  assign system_error_drive = addr_parity_err && par_en &&
    command_reg[pch_pkg::BIT_SYSERR_EN];
  assign parity_report = par_en &&
    (addr_parity_err || data_parity_err);
  assign master_grant_ok = master_req &&
    command_reg[pch_pkg::BIT_MASTER_EN];
  assign use_read_multiple = master_grant_ok && master_read &&
    fifo_free_words > cache_reg;
  assign claim_mem = mem_hit &&
    command_reg[pch_pkg::BIT_MEM_EN];
  assign claim_io = io_hit &&
    command_reg[pch_pkg::BIT_IO_EN];
  assign devsel_timing = pch_pkg::DEVSEL_MEDIUM;
  assign latency_limit = latency_reg;

endmodule

// File: src/pch_pkg.sv
// constants for the configuration header register block
package pch_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] OFF_COMMAND_STATUS = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV      = 8'h08;
  localparam logic [7:0] OFF_SELFTEST_LAT   = 8'h0C;
  localparam logic [7:0] OFF_DEVICE_CFG     = 8'h40;
  // command and device config bit positions
  localparam int BIT_IO_EN      = 0;
  localparam int BIT_MEM_EN     = 1;
  localparam int BIT_MASTER_EN  = 2;
  localparam int BIT_PARITY_EN  = 6;
  localparam int BIT_SYSERR_EN  = 8;
  localparam int BIT_CLASS_WREN = 0;
  // fixed status field values
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic       CAP_LIST      = 1'h1;
  // class code defaults
  localparam logic [23:0] CLASS_RAID = 24'h010400;
  localparam logic [23:0] CLASS_ATA  = 24'h010185;
  // external memory signatures
  localparam logic [15:0] EEPROM_SIG     = 16'h55AA;
  localparam logic [15:0] FLASH_SIG_HI   = 16'hAA55;
  localparam logic [7:0]  FLASH_SIG_LO   = 8'h55;
  localparam logic [18:0] FLASH_ADDR_HI  = 19'h7FFFE;
  localparam logic [18:0] FLASH_ADDR_LO  = 19'h7FFFC;
  localparam logic [7:0]  EEPROM_ADDR_HI = 8'h02;
  localparam logic [7:0]  EEPROM_ADDR_LO = 8'h00;
  // reset values and write masks
  localparam logic [8:0] COMMAND_RESET = 9'h000;
  localparam logic [7:0] LATENCY_RESET = 8'h00;
  localparam logic [7:0] CACHE_RESET   = 8'h00;
  localparam logic [7:0] LAT_MASK      = 8'hF0;
  localparam logic [7:0] CACHE_MASK    = 8'h3F;
  // load sequencer states
  typedef enum logic [4:0] {
    LD_IDLE  = 5'h01,
    LD_QUERY = 5'h02,
    LD_WAIT  = 5'h04,
    LD_CLASS = 5'h08,
    LD_DONE  = 5'h10
  } pch_load_e;
endpackage

// File: verification/pch_config_checker.sv
// port assertions for the configuration header register block
`timescale 1ns/1ps
module pch_config_checker (
  // clock, reset and access
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_ack,
  input wire logic        cfg_retry,
  // bus events and gating
  input wire logic        addr_parity_err,
  input wire logic        data_parity_err,
  input wire logic        system_error_drive,
  input wire logic        parity_report,
  input wire logic        master_req,
  input wire logic        master_read,
  input wire logic        master_grant_ok,
  input wire logic        use_read_multiple,
  input wire logic        mem_hit,
  input wire logic        io_hit,
  input wire logic        claim_mem,
  input wire logic        claim_io,
  input wire logic [1:0]  devsel_timing,
  input wire logic [7:0]  latency_limit
);
  // ==========
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  serr_gate_a: assert property (
    system_error_drive |-> addr_parity_err && parity_report)
    else $error("serr without cause");
  parity_cause_a: assert property (
    parity_report |-> addr_parity_err || data_parity_err)
    else $error("parity report without error");
  master_gate_a: assert property (
    use_read_multiple |-> master_grant_ok && master_read && master_req)
    else $error("read multiple without grant");
  claim_gate_a: assert property (
    (!claim_mem || mem_hit) && (!claim_io || io_hit))
    else $error("claim without hit");
  devsel_fixed_a: assert property (devsel_timing == 2'h1)
    else $error("devsel timing");
  lat_nibble_a: assert property (latency_limit[3:0] == 4'h0)
    else $error("latency low nibble");
  retry_noack_a: assert property (
    cfg_req && cfg_retry |=> !cfg_ack)
    else $error("ack after retry");
  status_read_a: assert property (
    cfg_ack && !$past(cfg_write) && $past(cfg_addr) == 8'h04 |->
    cfg_rdata[26:25] == 2'h1 && cfg_rdata[21:20] == 2'h1 &&
    cfg_rdata[19:9] == 11'h000 && cfg_rdata[7] == 1'b0 &&
    cfg_rdata[5:3] == 3'h0)
    else $error("status fixed bits");
  header_read_a: assert property (
    cfg_ack && !$past(cfg_write) && $past(cfg_addr) == 8'h0C |->
    cfg_rdata[31:16] == 16'h0000 && cfg_rdata[7:6] == 2'h0)
    else $error("header fixed bits");
endmodule
bind pch_config_regs pch_config_checker i_pch_config_checker (.*);

// File: verification/pch_config_regs_tb.sv
// self-checking bench for the configuration header register block
`timescale 1ns/1ps
module pch_config_regs_tb;
  localparam logic [7:0] REV = 8'h3C; // arbitrary revision value
  logic        sys_clk, rst_n, cfg_req, cfg_write, cfg_ack, cfg_retry;
  logic        class_select_strap, eeprom_present, flash_present, sig_ok;
  logic        mem_rd_req, mem_sel_flash, mem_rd_valid, saw_retry;
  logic        addr_parity_err, data_parity_err, system_error_drive;
  logic        parity_report, master_req, master_read, master_grant_ok;
  logic        use_read_multiple, mem_hit, io_hit, claim_mem, claim_io;
  logic [1:0]  devsel_timing;
  logic [3:0]  cfg_byte_en;
  logic [7:0]  cfg_addr, fifo_free_words, latency_limit;
  logic [15:0] mem_rd_data;
  logic [18:0] mem_addr;
  logic [23:0] class_image;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  int          fail_count, num_checks;
  pch_config_regs #(.REVISION_CODE(REV)) i_pch_config_regs (.*);
  pch_ext_memory i_pch_ext_memory (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    fail_count++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    test_done();
  end
  // ==========
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd);
    int n;
    n = 0;
    saw_retry = 1'b0;
    cfg_write = wr;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = wd;
    cfg_req = 1'b1;
    do begin
      #1;
      if (cfg_retry === 1'b1) saw_retry = 1'b1;
      @(posedge sys_clk);
      #1;
      n++;
    end while (cfg_ack !== 1'b1 && n < 500);
    if (n >= 500) begin
      fail_count++;
      $display("CHECK FAILED cfg_ack expected 1 seen %b", cfg_ack);
      test_done();
    end
    rd = cfg_rdata;
    cfg_req = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset(input logic s, e, f, ok);
    rst_n = 1'b0;
    class_select_strap = s;
    eeprom_present = e;
    flash_present = f;
    sig_ok = ok;
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
  endtask
  // ==========
  // scenarios
  task automatic t_reset_values();
    xfer(1'b0, 8'h04, 4'hF, 32'h0);
    chk("status", 32'h02100000, rd & 32'h063FFFFF);
    xfer(1'b0, 8'h0C, 4'hF, 32'h0);
    chk("header word", 32'h0, rd);
    chk("claims", 32'h0, {claim_mem, claim_io, master_grant_ok});
  endtask
  task automatic t_command();
    xfer(1'b1, 8'h04, 4'hF, 32'hFFFFFFFF);
    xfer(1'b0, 8'h04, 4'hF, 32'h0);
    chk("command", 32'h02100147, rd & 32'h063FFFFF);
    chk("claims", 32'h7, {claim_mem, claim_io, master_grant_ok});
    xfer(1'b1, 8'h04, 4'hF, 32'h00000001);
    chk("io only", 32'h2, {claim_mem, claim_io, master_grant_ok});
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h04, 4'h3, {23'h0, i[1], 1'b0, i[0], 6'h0});
      addr_parity_err = 1'b1;
      #1;
      chk("serr", {i == 3, i[0]}, {system_error_drive, parity_report});
      addr_parity_err = 1'b0;
    end
    data_parity_err = 1'b1;
    #1;
    chk("data parity", 32'h1, {system_error_drive, parity_report});
    data_parity_err = 1'b0;
  endtask
  task automatic t_latency();
    xfer(1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF);
    xfer(1'b0, 8'h0C, 4'hF, 32'h0);
    chk("latency word", 32'h0000F03F, rd);
    chk("latency limit", 32'hF0, latency_limit);
    xfer(1'b1, 8'h04, 4'hF, 32'h4);
    master_read = 1'b1;
    fifo_free_words = 8'h40;
    #1;
    chk("read multiple", 32'h1, use_read_multiple);
    fifo_free_words = 8'h3F;
    #1;
    chk("read single", 32'h0, use_read_multiple);
  endtask
  task automatic t_class(input logic [23:0] dflt);
    xfer(1'b0, 8'h08, 4'hF, 32'h0);
    chk("default class", {dflt, REV}, rd);
    xfer(1'b1, 8'h08, 4'hF, 32'hAABBCCDD);
    xfer(1'b0, 8'h08, 4'hF, 32'h0);
    chk("locked class", {dflt, REV}, rd);
    xfer(1'b1, 8'h40, 4'h1, 32'h1);
    xfer(1'b1, 8'h08, 4'hF, 32'hAABBCCDD);
    xfer(1'b0, 8'h08, 4'hF, 32'h0);
    chk("written class", {24'hAABBCC, REV}, rd);
  endtask
  task automatic t_load(input logic e, f, ok, input logic [23:0] exp);
    do_reset(1'b0, e, f, ok);
    xfer(1'b0, 8'h08, 4'hF, 32'h0);
    chk("retry", 32'h1, saw_retry);
    chk("loaded class", {exp, REV}, rd);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    fail_count = 0;
    num_checks = 0;
    cfg_req = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
    addr_parity_err = 1'b0;
    data_parity_err = 1'b0;
    master_req = 1'b1;
    master_read = 1'b0;
    fifo_free_words = 8'h00;
    mem_hit = 1'b1;
    io_hit = 1'b1;
    class_image = 24'h0C0A0B;
    do_reset(1'b1, 1'b0, 1'b0, 1'b1);
    t_reset_values();
    t_command();
    t_latency();
    t_class(pch_pkg::CLASS_ATA);
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    t_class(pch_pkg::CLASS_RAID);
    t_load(1'b0, 1'b1, 1'b1, 24'h0C0A0B);
    class_image = 24'h123456;
    t_load(1'b1, 1'b0, 1'b1, 24'h123456);
    t_load(1'b1, 1'b0, 1'b0, pch_pkg::CLASS_RAID);
    test_done();
  end
endmodule

// File: verification/pch_ext_memory.sv
// external class code memory model on the loader port
`timescale 1ns/1ps
module pch_ext_memory #(
  parameter int DELAY = 2
) (
  // clock and stored image
  input  wire logic        sys_clk,
  input  wire logic [23:0] class_image,
  input  wire logic        sig_ok,
  // loader port
  input  wire logic        mem_rd_req,
  input  wire logic        mem_sel_flash,
  input  wire logic [18:0] mem_addr,
  output logic             mem_rd_valid,
  output logic      [15:0] mem_rd_data
);
  logic [15:0] word;
  int          wait_cnt = 0;
  initial begin
    mem_rd_valid = 1'b0;
    mem_rd_data  = 16'hA5C3;
  end
  always @(posedge sys_clk) begin
    #1;
    mem_rd_valid = 1'b0;
    mem_rd_data  = ~mem_rd_data; // idle data never holds
    if (wait_cnt == 1) begin
      mem_rd_valid = 1'b1;
      mem_rd_data  = word;
    end
    if (wait_cnt > 0) begin
      wait_cnt = wait_cnt - 1;
    end else if (mem_rd_req === 1'b1) begin
      wait_cnt = DELAY;
      case ({mem_sel_flash, mem_addr})
        20'hFFFFE: word = 16'hAA55;
        20'hFFFFC: word = 16'h0055;
        20'h00002, 20'h00000: word = 16'h55AA;
        default: word = {8'h00, class_image[8*mem_addr[1:0] +: 8]};
      endcase
      if (!sig_ok) begin
        word = ~word;
      end
    end
  end
endmodule
